//--- core/isp_top.sv
// in-system flash programming sequencer with its register port
//
// The implementer's own choice: the plain strobed port.
`include "isp_defs.svh"
`default_nettype none

// Behaviour
// - flash is 128 pages of 32 bytes
// - page program copies 32 ram bytes to page
// - page target from address bits 15..5, aligned
// - command 0x5A starts page program
// - command 0x1E starts byte program
// - byte source is ram at buffer pointer
// - byte target is full 16-bit address
// - buffer pointer 8-bit read/write, resets zero
// - watchdog keeps running while programming
// - pages 0 to 7 vector, page 127 power-on data
// - vector region begins at flash address 0000

module isp_top
    import isp_pkg::*;
#(
    parameter int FIFO_DEPTH = `ISP_FIFO_DEPTH
) (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    output logic             ram_rd_en_out,
    output logic      [7:0]  ram_rd_addr_out,
    input  wire logic [7:0]  ram_rd_data_in,
    output logic             flash_wr_out,
    output logic      [15:0] flash_addr_out,
    output logic      [7:0]  flash_data_out,
    input  wire logic        flash_busy_in,
    output logic             fetch_stall_out
);

    // ==========================================================
    // parameter check
    generate
        if (FIFO_DEPTH < 2) begin : g_bad
            $error("isp_top: FIFO_DEPTH must be at least 2");
        end
    endgenerate

    localparam isp_seq_s SEQ_RST = '{st: ST_IDLE, default: '0};

    isp_seq_s   q;
    isp_seq_s   n;
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic       fifo_out_ready;
    logic       cmd_wr;
    logic       rd_issue;
    logic       wr_issue;
    logic [6:0] tgt_page;

    // ==========================================================
    // staging fifo, ram side fills, flash side drains
    isp_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_in    (clk_sys_in),
        .rst_in        (rst_in),
        .in_valid_in   (q.rd_pend),
        .in_data_in    (ram_rd_data_in),
        .in_ready_out  (fifo_in_ready),
        .out_valid_out (fifo_out_valid),
        .out_data_out  (fifo_out_data),
        .out_ready_in  (fifo_out_ready)
    );

    // ==========================================================
    // next state
    always_comb begin
        n        = q;
        n.ram_en = 1'b0;
        n.fl_wr  = 1'b0;
        n.rdata  = `ISP_RST_REG;
        // ram data stand one cycle after the request, push then
        n.rd_pend = q.ram_en;
        cmd_wr   = reg_wr_in && (reg_addr_in == `ISP_OFS_CMD);
        tgt_page = {q.adr_h[`ISP_PAGE_MSB-8:0], q.adr_l[7:`ISP_PAGE_LSB]};

        // one ram read in flight at a time, gated by fifo room
        rd_issue = (q.st == ST_RUN) && (q.rd_cnt != q.len) && !q.ram_en
                   && !q.rd_pend && fifo_in_ready;
        // flash must report busy in the cycle after a strobe
        wr_issue = (q.st != ST_IDLE) && fifo_out_valid && !flash_busy_in
                   && !q.wr_gap && (q.wr_cnt != q.len);
        fifo_out_ready = wr_issue;
        n.wr_gap = wr_issue;

        // register writes; address stays writable while busy
        if (reg_wr_in) begin
            case (reg_addr_in)
                `ISP_OFS_PTR:   n.ptr   = reg_wdata_in;
                `ISP_OFS_ADR_H: n.adr_h = reg_wdata_in;
                `ISP_OFS_ADR_L: n.adr_l = reg_wdata_in;
                default:        n.ptr   = q.ptr;
            endcase
        end

        // register reads, data one cycle later; command reads zero
        if (reg_rd_in) begin
            case (reg_addr_in)
                `ISP_OFS_PTR:    n.rdata = q.ptr;
                `ISP_OFS_ADR_H:  n.rdata = q.adr_h;
                `ISP_OFS_ADR_L:  n.rdata = q.adr_l;
                `ISP_OFS_STATUS: begin
                    n.rdata[`ISP_STB_BUSY] = q.stall;
                    n.rdata[`ISP_STB_VEC]  = q.hit_vec;
                    n.rdata[`ISP_STB_LAST] = q.hit_last;
                    n.rdata[`ISP_STB_RSVD] = q.rsvd_cmd;
                end
                default:         n.rdata = `ISP_RST_REG;
            endcase
        end

        // ram read side
        if (rd_issue) begin
            n.ram_en   = 1'b1;
            n.ram_addr = q.base_ptr + {2'b00, q.rd_cnt};
            n.rd_cnt   = q.rd_cnt + 6'h01;
        end

        // flash write side
        if (wr_issue) begin
            n.fl_wr   = 1'b1;
            n.fl_data = fifo_out_data;
            n.wr_cnt  = q.wr_cnt + 6'h01;
            if (q.page_mode) begin
                n.fl_addr = {q.base_adr[15:`ISP_PAGE_LSB], q.wr_cnt[4:0]};
            end else begin
                n.fl_addr = q.base_adr;
            end
        end

        case (q.st)
            ST_IDLE: begin
                if (cmd_wr) begin
                    if (reg_wdata_in == `ISP_CMD_PAGE) begin
                        n.st        = ST_RUN;
                        n.page_mode = 1'b1;
                        n.len       = `ISP_PAGE_BYTES;
                        n.base_adr  = {q.adr_h, q.adr_l[7:`ISP_PAGE_LSB], 5'h00};
                    end else if (reg_wdata_in == `ISP_CMD_BYTE) begin
                        n.st        = ST_RUN;
                        n.page_mode = 1'b0;
                        n.len       = `ISP_BYTE_LEN;
                        n.base_adr  = {q.adr_h, q.adr_l};
                    end else begin
                        // reserved code: no operation, only flagged
                        n.rsvd_cmd = 1'b1;
                    end
                    if (reg_wdata_in == `ISP_CMD_PAGE || reg_wdata_in == `ISP_CMD_BYTE) begin
                        n.base_ptr = q.ptr;
                        n.rd_cnt   = 6'h00;
                        n.wr_cnt   = 6'h00;
                        n.stall    = 1'b1;
                        n.rsvd_cmd = 1'b0;
                        n.hit_vec  = (tgt_page < `ISP_VEC_PAGES);
                        n.hit_last = (tgt_page == `ISP_LAST_PAGE);
                    end
                end
            end
            ST_RUN: begin
                if (wr_issue && (q.wr_cnt + 6'h01 == q.len)) begin
                    n.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // last strobe must settle before fetch resumes
                if (!q.wr_gap && !flash_busy_in) begin
                    n.st    = ST_IDLE;
                    n.stall = 1'b0;
                end
            end
            default: begin
                n.st    = ST_IDLE;
                n.stall = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            q <= SEQ_RST;
        end else begin
            q <= n;
        end
    end

    // ==========================================================
    // outputs, all from the state register
    // no watchdog hold here: software must clear it before starting
    assign reg_rdata_out   = q.rdata;
    assign ram_rd_en_out   = q.ram_en;
    assign ram_rd_addr_out = q.ram_addr;
    assign flash_wr_out    = q.fl_wr;
    assign flash_addr_out  = q.fl_addr;
    assign flash_data_out  = q.fl_data;
    assign fetch_stall_out = q.stall;

    // ==========================================================
    // checks
    a_page_start: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (q.st == ST_IDLE && cmd_wr && reg_wdata_in == `ISP_CMD_PAGE)
        |=> (q.st == ST_RUN && q.page_mode && fetch_stall_out))
        else $error("page command did not start page program");

    a_byte_start: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (q.st == ST_IDLE && cmd_wr && reg_wdata_in == `ISP_CMD_BYTE)
        |=> (q.st == ST_RUN && !q.page_mode && q.len == `ISP_BYTE_LEN))
        else $error("byte command did not start byte program");

    a_page_align: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (flash_wr_out && q.page_mode)
        |-> (flash_addr_out[15:5] == q.base_adr[15:5]
             && q.base_adr[4:0] == 5'h00))
        else $error("page write outside aligned target page");

    a_byte_addr: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (flash_wr_out && !q.page_mode) |-> (flash_addr_out == q.base_adr))
        else $error("byte write at wrong address");

    a_page_count: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ($fell(fetch_stall_out) && q.page_mode) |-> (q.wr_cnt == `ISP_PAGE_BYTES))
        else $error("page program did not write 32 bytes");

    a_byte_src: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (ram_rd_en_out && !q.page_mode) |-> (ram_rd_addr_out == q.base_ptr))
        else $error("byte source not at buffer pointer");

    a_ptr_write: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (reg_wr_in && reg_addr_in == `ISP_OFS_PTR)
        |=> (q.ptr == $past(reg_wdata_in)))
        else $error("buffer pointer write lost");

    a_ptr_read: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (reg_rd_in && reg_addr_in == `ISP_OFS_PTR && !reg_wr_in)
        |=> (reg_rdata_out == $past(q.ptr)))
        else $error("buffer pointer read back wrong");

    a_stall_busy: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (q.st != ST_IDLE) |-> fetch_stall_out)
        else $error("fetch not stalled during programming");

    a_last_flag: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (q.st == ST_IDLE && cmd_wr && reg_wdata_in == `ISP_CMD_PAGE
         && {q.adr_h[3:0], q.adr_l[7:5]} == `ISP_LAST_PAGE)
        |=> q.hit_last)
        else $error("last page target not flagged");

    a_vec_flag: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (q.st == ST_IDLE && cmd_wr
         && (reg_wdata_in == `ISP_CMD_PAGE || reg_wdata_in == `ISP_CMD_BYTE)
         && {q.adr_h[3:0], q.adr_l[7:5]} < `ISP_VEC_PAGES)
        |=> q.hit_vec)
        else $error("vector region target not flagged");

    a_rsvd_ignore: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (q.st == ST_IDLE && cmd_wr && reg_wdata_in != `ISP_CMD_PAGE
         && reg_wdata_in != `ISP_CMD_BYTE)
        |=> (q.st == ST_IDLE && q.rsvd_cmd && !fetch_stall_out))
        else $error("reserved command started an operation");

    a_one_strobe: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        flash_wr_out |=> !flash_wr_out)
        else $error("flash strobes back to back");

endmodule : isp_top

`default_nettype wire

//--- core/isp_defs.svh
// register map, command codes and layout constants of the flash programmer
`ifndef ISP_DEFS_SVH
`define ISP_DEFS_SVH

// ==========================================================
// register offsets
`define ISP_OFS_CMD     8'h94
`define ISP_OFS_ADR_L   8'h95
`define ISP_OFS_ADR_H   8'h96
`define ISP_OFS_PTR     8'h97
`define ISP_OFS_STATUS  8'h98

// ==========================================================
// reset values and command codes
`define ISP_RST_REG     8'h00
`define ISP_CMD_PAGE    8'h5A
`define ISP_CMD_BYTE    8'h1E

// ==========================================================
// flash layout
`define ISP_PAGE_BYTES  6'h20
`define ISP_BYTE_LEN    6'h01
`define ISP_PAGE_COUNT  128
`define ISP_PAGE_MSB    11
`define ISP_PAGE_LSB    5
`define ISP_LAST_PAGE   7'h7F
`define ISP_VEC_PAGES   7'h08
`define ISP_FIFO_DEPTH  8

// ==========================================================
// status register bit positions
`define ISP_STB_BUSY    0
`define ISP_STB_VEC     1
`define ISP_STB_LAST    2
`define ISP_STB_RSVD    3

`endif

//--- core/isp_pkg.sv
// types shared by the flash programmer
`default_nettype none

package isp_pkg;

    // ==========================================================
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_RUN  = 3'h2,
        ST_WAIT = 3'h4
    } isp_state_e;

    // ==========================================================
    // whole state of the sequencer
    typedef struct packed {
        isp_state_e  st;
        logic [7:0]  ptr;
        logic [7:0]  adr_h;
        logic [7:0]  adr_l;
        logic [7:0]  base_ptr;
        logic [15:0] base_adr;
        logic        page_mode;
        logic [5:0]  len;
        logic [5:0]  rd_cnt;
        logic [5:0]  wr_cnt;
        logic        rd_pend;
        logic        wr_gap;
        logic        ram_en;
        logic [7:0]  ram_addr;
        logic        fl_wr;
        logic [15:0] fl_addr;
        logic [7:0]  fl_data;
        logic        stall;
        logic [7:0]  rdata;
        logic        hit_vec;
        logic        hit_last;
        logic        rsvd_cmd;
    } isp_seq_s;

endpackage : isp_pkg

`default_nettype wire

//--- core/isp_fifo.sv
// byte fifo between data ram reads and flash writes, registered head
`default_nettype none

module isp_fifo
    import isp_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rst_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    // ==========================================================
    // parameter check
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
            $error("isp_fifo: DEPTH must be a power of two >= 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [CW-1:0]               cnt;
        logic                        ov;
        logic [WIDTH-1:0]            od;
    } isp_fifo_s;

    isp_fifo_s q;
    isp_fifo_s n;
    logic      push;
    logic      pop;
    logic      take;
    logic      bypass;

    // ==========================================================
    // next state
    always_comb begin
        n            = q;
        take         = 1'b0;
        bypass       = 1'b0;
        in_ready_out = (q.cnt != CW'(DEPTH));
        push         = in_valid_in & in_ready_out;
        pop          = q.ov & out_ready_in;
        if (!q.ov || pop) begin
            if (q.cnt != '0) begin
                n.od = q.mem[q.rp];
                n.rp = q.rp + 1'b1;
                n.ov = 1'b1;
                take = 1'b1;
            end else if (push) begin
                // empty store: word goes straight to the head
                n.od   = in_data_in;
                n.ov   = 1'b1;
                bypass = 1'b1;
            end else begin
                n.ov = 1'b0;
            end
        end
        if (push && !bypass) begin
            n.mem[q.wp] = in_data_in;
            n.wp        = q.wp + 1'b1;
        end
        if (push && !bypass && !take) begin
            n.cnt = q.cnt + 1'b1;
        end else if (take && !(push && !bypass)) begin
            n.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign out_valid_out = q.ov;
    assign out_data_out  = q.od;

endmodule : isp_fifo

`default_nettype wire

//--- sim/isp_mem_model.sv
// data ram and program flash model facing the programming sequencer
`default_nettype none

module isp_mem_model (
    input  wire logic        clk_sys_in,
    input  wire logic        ram_rd_en_in,
    input  wire logic [7:0]  ram_rd_addr_in,
    output logic      [7:0]  ram_rd_data_out,
    input  wire logic        flash_wr_in,
    input  wire logic [15:0] flash_addr_in,
    input  wire logic [7:0]  flash_data_in,
    output logic             flash_busy_out,
    input  wire logic [3:0]  busy_len_in,
    output logic      [7:0]  fault_cnt_out
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] mem [256];
    logic [3:0] busy_cnt = 4'h0;
    logic       wr_last  = 1'b0;

    initial begin
        ram_rd_data_out = 8'h00;
        flash_busy_out  = 1'b0;
        fault_cnt_out   = 8'h00;
    end

    // ==========================================================
    // data ram: answer one cycle after request, garbage otherwise
    always @(posedge clk_sys_in) begin
        if (ram_rd_en_in === 1'b1) begin
            ram_rd_data_out <= mem[ram_rd_addr_in];
        end else begin
            ram_rd_data_out <= ~ram_rd_data_out;
        end
    end

    // ==========================================================
    // flash: busy for busy_len cycles after each strobe
    // a strobe while busy or back to back is counted, not absorbed
    always @(posedge clk_sys_in) begin
        wr_last <= flash_wr_in;
        if (flash_wr_in === 1'b1) begin
            if (flash_busy_out || wr_last) begin
                fault_cnt_out <= fault_cnt_out + 8'h01;
            end
            busy_cnt       <= busy_len_in;
            flash_busy_out <= (busy_len_in != 4'h0);
        end else if (busy_cnt > 4'h1) begin
            busy_cnt <= busy_cnt - 4'h1;
        end else begin
            busy_cnt       <= 4'h0;
            flash_busy_out <= 1'b0;
        end
    end
endmodule : isp_mem_model

`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench of the flash programming sequencer
`include "isp_defs.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk_sys_in   = 1'b0;
    logic        rst_in       = 1'b1;
    logic [7:0]  reg_addr_in  = 8'h00;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        reg_wr_in    = 1'b0;
    logic        reg_rd_in    = 1'b0;
    logic [3:0]  busy_len     = 4'h0;
    logic [7:0]  reg_rdata_out;
    logic        ram_rd_en_out;
    logic [7:0]  ram_rd_addr_out;
    logic [7:0]  ram_rd_data_in;
    logic        flash_wr_out;
    logic [15:0] flash_addr_out;
    logic [7:0]  flash_data_out;
    logic        flash_busy_in;
    logic        fetch_stall_out;
    logic [7:0]  fault_cnt;
    int          num_errors   = 0;
    int          total_checks = 0;
    int          seed         = 32'h71b4;
    logic [15:0] exp_a [$];
    logic [15:0] got_a [$];
    logic [7:0]  exp_d [$];
    logic [7:0]  got_d [$];

    always #25 clk_sys_in = ~clk_sys_in;

    isp_top DUT (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .ram_rd_en_out(ram_rd_en_out),
        .ram_rd_addr_out(ram_rd_addr_out), .ram_rd_data_in(ram_rd_data_in),
        .flash_wr_out(flash_wr_out), .flash_addr_out(flash_addr_out),
        .flash_data_out(flash_data_out), .flash_busy_in(flash_busy_in),
        .fetch_stall_out(fetch_stall_out)
    );

    isp_mem_model PART (
        .clk_sys_in(clk_sys_in), .ram_rd_en_in(ram_rd_en_out),
        .ram_rd_addr_in(ram_rd_addr_out), .ram_rd_data_out(ram_rd_data_in),
        .flash_wr_in(flash_wr_out), .flash_addr_in(flash_addr_out),
        .flash_data_in(flash_data_out), .flash_busy_out(flash_busy_in),
        .busy_len_in(busy_len), .fault_cnt_out(fault_cnt)
    );

    // ==========================================================
    // checking and bus tasks
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in    <= 1'b0;
    endtask : reg_wr

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in   <= 1'b0;
        #1;
        chk(name, {8'h00, e}, {8'h00, reg_rdata_out});
        @(posedge clk_sys_in);
        #1;
        chk("read data released", 16'h0000, {8'h00, reg_rdata_out});
    endtask : rd_chk

    // ==========================================================
    // flash write monitor
    always @(posedge clk_sys_in) begin
        if (flash_wr_out === 1'b1) begin
            got_a.push_back(flash_addr_out);
            got_d.push_back(flash_data_out);
            chk("stall during write", 16'h0001, {15'h0000, fetch_stall_out});
        end
    end

    // ==========================================================
    // one program operation against the queue model
    task automatic run_op(input logic [7:0] cmd, input logic [7:0] ptr,
                          input logic [15:0] adr, input logic [3:0] blen, input bit meddle);
        logic [15:0] base;
        logic [7:0]  st_exp;
        int          n;
        int          wait_cnt;
        busy_len = blen;
        reg_wr(`ISP_OFS_PTR, ptr);
        reg_wr(`ISP_OFS_ADR_H, adr[15:8]);
        reg_wr(`ISP_OFS_ADR_L, adr[7:0]);
        n    = (cmd == `ISP_CMD_PAGE) ? 32 : 1;
        base = (n == 32) ? {adr[15:5], 5'h00} : adr;
        for (int i = 0; i < n; i++) begin
            exp_a.push_back(base + 16'(i));
            exp_d.push_back(PART.mem[8'(ptr + i)]);
        end
        st_exp                = 8'h00;
        st_exp[`ISP_STB_VEC]  = (adr[11:5] < `ISP_VEC_PAGES);
        st_exp[`ISP_STB_LAST] = (adr[11:5] == `ISP_LAST_PAGE);
        reg_wr(`ISP_OFS_CMD, cmd);
        #1;
        chk("stall rises", 16'h0001, {15'h0000, fetch_stall_out});
        repeat (2) @(posedge clk_sys_in);
        if (meddle) begin
            // values latched at start must win over late writes
            reg_wr(`ISP_OFS_PTR, ~ptr);
            reg_wr(`ISP_OFS_CMD, `ISP_CMD_BYTE);
            rd_chk("status while busy", `ISP_OFS_STATUS, st_exp | 8'h01);
        end
        wait_cnt = 0;
        while (fetch_stall_out !== 1'b0 && wait_cnt < 2000) begin
            @(posedge clk_sys_in);
            #1;
            wait_cnt++;
        end
        chk("stall falls", 16'h0000, {15'h0000, fetch_stall_out});
        chk("write count", 16'(n), 16'(got_a.size()));
        while (got_a.size() > 0 && exp_a.size() > 0) begin
            chk("flash addr", exp_a.pop_front(), got_a.pop_front());
            chk("flash data", {8'h00, exp_d.pop_front()}, {8'h00, got_d.pop_front()});
        end
        exp_a.delete();
        exp_d.delete();
        got_a.delete();
        got_d.delete();
        rd_chk("status after op", `ISP_OFS_STATUS, st_exp);
    endtask : run_op

    // ==========================================================
    // main sequence
    initial begin
        logic [7:0] v;
        for (int i = 0; i < 256; i++) begin
            PART.mem[i] = 8'($random(seed));
        end
        repeat (4) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd_chk("reset value", 8'h94 + 8'(i), `ISP_RST_REG);
        end
        reg_wr(8'h50, 8'hff);
        rd_chk("unmapped read", 8'h50, 8'h00);
        for (int i = 1; i < 4; i++) begin
            v = 8'($random(seed));
            reg_wr(8'h94 + 8'(i), v);
            rd_chk("register readback", 8'h94 + 8'(i), v);
        end
        run_op(`ISP_CMD_PAGE, 8'h60, 16'h0fc0, 4'h0, 1'b0);
        run_op(`ISP_CMD_PAGE, 8'hf0, 16'h0013, 4'h3, 1'b1);
        run_op(`ISP_CMD_PAGE, 8'h07, 16'h0ffd, 4'h6, 1'b0);
        run_op(`ISP_CMD_BYTE, 8'h60, 16'h0fc5, 4'h2, 1'b0);
        reg_wr(`ISP_OFS_CMD, 8'h33);
        repeat (40) @(posedge clk_sys_in);
        #1;
        chk("no stall on reserved", 16'h0000, {15'h0000, fetch_stall_out});
        chk("no write on reserved", 16'h0000, 16'(got_a.size()));
        rd_chk("status reserved", `ISP_OFS_STATUS, 8'h08);
        for (int k = 0; k < 6; k++) begin
            v = 8'($random(seed));
            run_op(v[0] ? `ISP_CMD_PAGE : `ISP_CMD_BYTE, 8'($random(seed)),
                   (16'($random(seed)) & 16'h0fbf) | 16'h0100, {1'b0, v[3:1]}, 1'b0);
        end
        chk("flash protocol faults", 16'h0000, {8'h00, fault_cnt});
        end_sim();
    end

    // ==========================================================
    // watchdog: the whole sequence needs well under 10000 cycles
    initial begin
        #2000000;
        num_errors++;
        end_sim();
    end
endmodule : tb_top

`default_nettype wire
